// ---- include/mic_defines.svh ----
// Constants of the interrupt controller: register indices, masks, field
// positions, source locators and vector layout.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

// ==========================================================================
// Register indices on the register port
`define MIC_REG_EDGE   3'h0
`define MIC_REG_PRI0   3'h1
`define MIC_REG_PRI1   3'h2
`define MIC_REG_PRI2   3'h3
`define MIC_REG_PRI3   3'h4
`define MIC_REG_SHR0   3'h5
`define MIC_REG_SHR1   3'h6
`define MIC_REG_SHR2   3'h7
`define MIC_REG_COUNT  8

// ==========================================================================
// Implemented bits; the rest read as zero
`define MIC_MASK_EDGE  8'h3f
`define MIC_MASK_PRI0  8'h7f
`define MIC_MASK_FULL  8'hff
`define MIC_MASK_HALF  8'h33
`define MIC_RESET_VAL  8'h00

// ==========================================================================
// Fields: global enable, edge-select positions, source nibbles
`define MIC_GIE_BIT    3'h0
`define MIC_PIN0_SEL   1:0
`define MIC_PIN1_SEL   3:2
`define MIC_PIN2_SEL   5:4
`define MIC_FLAG_NIB   7:4
`define MIC_EN_NIB     3:0

// ==========================================================================
// Source locators {register, flag bit, enable bit}, highest priority first
`define MIC_LOC_PIN0   9'({3'h1, 3'h4, 3'h1})
`define MIC_LOC_CMP    9'({3'h1, 3'h5, 3'h2})
`define MIC_LOC_GRP0   9'({3'h1, 3'h6, 3'h3})
`define MIC_LOC_GRP1   9'({3'h2, 3'h4, 3'h0})
`define MIC_LOC_GRP2   9'({3'h2, 3'h5, 3'h1})
`define MIC_LOC_ADC    9'({3'h2, 3'h6, 3'h2})
`define MIC_LOC_TICK0  9'({3'h2, 3'h7, 3'h3})
`define MIC_LOC_TICK1  9'({3'h3, 3'h4, 3'h0})
`define MIC_LOC_PIN1   9'({3'h3, 3'h5, 3'h1})
`define MIC_LOC_SER    9'({3'h3, 3'h6, 3'h2})
`define MIC_LOC_ASYN0  9'({3'h3, 3'h7, 3'h3})
`define MIC_LOC_ASYN1  9'({3'h4, 3'h4, 3'h0})
`define MIC_LOC_PIN2   9'({3'h4, 3'h5, 3'h1})
`define MIC_NUM_SRC    13

// ==========================================================================
// Vector addresses: base plus index times step
`define MIC_VEC_W      8
`define MIC_VEC_BASE   8'h04
`define MIC_VEC_STEP   8'h04

`endif

// ---- include/mic_pkg.sv ----
// Types of the interrupt controller: source events and the core request.
// Assumes mic_defines.svh is on the include path.
`include "mic_defines.svh"
`default_nettype none

package mic_pkg;

  // ========================================================================
  // One-cycle event pulses from the on-chip sources
  typedef struct packed {
    logic comparator;
    logic conversion_done;
    logic tick0;
    logic tick1;
    logic serial_if;
    logic async0;
    logic async1;
    logic timer_a_match_a;
    logic timer_a_match_p;
    logic timer_b_match_a;
    logic timer_b_match_p;
    logic timer_c_match_a;
    logic timer_c_match_p;
    logic timer_d_match_a;
    logic timer_d_match_p;
    logic eeprom_done;
    logic low_supply;
  } mic_src_t;

  // ========================================================================
  // Request handed to the core when an interrupt is accepted
  typedef struct packed {
    logic                  take;
    logic [3:0]            index;
    logic [`MIC_VEC_W-1:0] vector;
  } mic_irq_t;

endpackage

`default_nettype wire

// ---- rtl/mic_edge_detect.sv ----
// Edge detector for one external request pin with a two-bit mode.
// Assumes the pin is already synchronous to clock.
`include "mic_defines.svh"
`default_nettype none

module mic_edge_detect (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  output logic            hit
);

  logic prev_q;
  logic armed_q;

  // ========================================================================
  // Previous level; armed only after the first sample, no false edge at reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_q  <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      prev_q  <= pin;
      armed_q <= 1'b1;
    end
  end

  // Bit 0 picks rising, bit 1 falling; 00 turns the pin off
  assign hit = armed_q & ((mode[0] & pin & ~prev_q) | (mode[1] & ~pin & prev_q));

endmodule

`default_nettype wire

// ---- rtl/mic_intc.sv ----
// Interrupt controller: request flags, enables, fixed priority and vectors.
// Assumes a core that pushes irq_ret_addr and jumps on irq.take, and
// sources that pulse their event for one cycle.
//
// Summary of operation
// - Each pin has a two-bit edge mode: off, rising, falling, both.
// - Unimplemented bits of edge, primary and shared registers read zero.
// - A source event sets its request flag; zero means nothing pending.
// - A set flag jumps to its vector only while its enable is one.
// - With the global enable at zero no interrupt is accepted.
// - Accepting pushes the next address and loads the source vector.
// - The service routine ends with a return that pops the saved address.
// - Servicing clears the global enable automatically.
// - Requests during blocking still set their flags and stay pending.
// - Software setting the global enable again allows nesting.
// - No request is acknowledged while the return stack is full.
// - Simultaneous enabled requests are chosen by fixed priority.
// - Some sources vector directly, others through shared group vectors.
// - Any flag newly set by a source event wakes the part from low-power modes; a register write that sets a flag does not.
// - Each timer has separate match A and match P flags and enables.
// - A group flag sets when any member source whose enable is one has an event.
// - Servicing a group vector clears only the group flag.
// - Servicing a direct vector clears that source's flag.
`include "mic_defines.svh"
`default_nettype none

module mic_intc #(
  parameter int PC_W = 14
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [2:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  input  wire logic [2:0]        ext_pin,
  input  wire mic_pkg::mic_src_t src_event,
  input  wire logic              stack_full,
  input  wire logic [PC_W-1:0]   next_pc,
  output mic_pkg::mic_irq_t      irq,
  output logic [PC_W-1:0]        irq_ret_addr,
  output logic                   wake
);

  // ========================================================================
  // Storage and constant tables
  localparam logic [8:0] LOC [`MIC_NUM_SRC] = '{
    `MIC_LOC_PIN0, `MIC_LOC_CMP, `MIC_LOC_GRP0, `MIC_LOC_GRP1, `MIC_LOC_GRP2,
    `MIC_LOC_ADC, `MIC_LOC_TICK0, `MIC_LOC_TICK1, `MIC_LOC_PIN1, `MIC_LOC_SER,
    `MIC_LOC_ASYN0, `MIC_LOC_ASYN1, `MIC_LOC_PIN2};
  localparam logic [7:0] MASK [`MIC_REG_COUNT] = '{
    `MIC_MASK_EDGE, `MIC_MASK_PRI0, `MIC_MASK_FULL, `MIC_MASK_FULL,
    `MIC_MASK_HALF, `MIC_MASK_FULL, `MIC_MASK_FULL, `MIC_MASK_HALF};

  logic [7:0]             regs_q  [`MIC_REG_COUNT];
  logic [7:0]             regs_d  [`MIC_REG_COUNT];
  logic [7:0]             ev      [`MIC_REG_COUNT];
  logic [7:0]             clr     [`MIC_REG_COUNT];
  logic [7:0]             wake_vec[`MIC_REG_COUNT];
  logic [7:0]             rdata_q;
  logic [PC_W-1:0]        ret_q;
  logic                   wake_q;
  mic_pkg::mic_irq_t      irq_q;
  mic_pkg::mic_irq_t      irq_d;

  // ========================================================================
  // External pins: one edge detector each
  logic [2:0] pin_hit;
  logic [5:0] edge_sel;
  assign edge_sel = regs_q[`MIC_REG_EDGE][5:0];

  for (genvar p = 0; p < 3; p++)
  begin : g_pin
    mic_edge_detect u_edge (
      .clock (clock),
      .rst   (rst),
      .pin   (ext_pin[p]),
      .mode  (edge_sel[2*p +: 2]),
      .hit   (pin_hit[p])
    );
  end

  // ========================================================================
  // Group requests: member events gated by member enables
  logic [3:0] shr_ev [3];
  logic [2:0] grp_hit;
  assign shr_ev[0] = {src_event.timer_c_match_a, src_event.timer_c_match_p,
                      src_event.timer_b_match_a, src_event.timer_b_match_p};
  assign shr_ev[1] = {src_event.timer_a_match_a, src_event.timer_a_match_p,
                      src_event.timer_d_match_a, src_event.timer_d_match_p};
  assign shr_ev[2] = {2'b00, src_event.eeprom_done, src_event.low_supply};

  for (genvar g = 0; g < 3; g++)
  begin : g_grp
    assign grp_hit[g] = |(shr_ev[g] & regs_q[`MIC_REG_SHR0 + g][`MIC_EN_NIB]);
  end

  // ========================================================================
  // Event vectors laid over the flag positions of each register
  assign ev[`MIC_REG_EDGE] = 8'h00;
  assign ev[`MIC_REG_PRI0] = {1'b0, grp_hit[0], src_event.comparator, pin_hit[0], 4'h0};
  assign ev[`MIC_REG_PRI1] = {src_event.tick0, src_event.conversion_done,
                              grp_hit[2], grp_hit[1], 4'h0};
  assign ev[`MIC_REG_PRI2] = {src_event.async0, src_event.serial_if,
                              pin_hit[1], src_event.tick1, 4'h0};
  assign ev[`MIC_REG_PRI3] = {2'b00, pin_hit[2], src_event.async1, 4'h0};
  assign ev[`MIC_REG_SHR0] = {shr_ev[0], 4'h0};
  assign ev[`MIC_REG_SHR1] = {shr_ev[1], 4'h0};
  assign ev[`MIC_REG_SHR2] = {shr_ev[2], 4'h0};

  // ========================================================================
  // Pending requests and fixed-priority choice
  logic [`MIC_NUM_SRC-1:0] pend;
  logic                    gie;
  logic                    any_pend;
  logic [3:0]              win;
  logic                    accept;

  for (genvar s = 0; s < `MIC_NUM_SRC; s++)
  begin : g_pend
    assign pend[s] = regs_q[LOC[s][8:6]][LOC[s][5:3]] & regs_q[LOC[s][8:6]][LOC[s][2:0]];
  end

  // Lowest index wins; the order is fixed by the locator table
  function automatic logic [3:0] first_set(input logic [`MIC_NUM_SRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `MIC_NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign gie      = regs_q[`MIC_REG_PRI0][`MIC_GIE_BIT];
  assign any_pend = |pend;
  assign win      = first_set(pend);
  // Stack full only defers; the flag stays and is taken once room returns
  assign accept   = gie & ~stack_full & any_pend;

  assign irq_d.take   = accept;
  assign irq_d.index  = win;
  assign irq_d.vector = `MIC_VEC_BASE + `MIC_VEC_W'(win) * `MIC_VEC_STEP;

  // ========================================================================
  // Next register values: write, then service clear, then events win
  for (genvar r = 0; r < `MIC_REG_COUNT; r++)
  begin : g_reg
    logic [7:0] wr_val;
    assign clr[r] = (accept && LOC[win][8:6] == 3'(r)) ? 8'(8'h01 << LOC[win][5:3]) : 8'h00;
    assign wr_val = (reg_wr && reg_addr == 3'(r)) ? (reg_wdata & MASK[r]) : regs_q[r];
    // Service clears only the chosen flag, so group members stay set
    assign regs_d[r] = ((wr_val & ~clr[r]
                      & ~((accept && r == `MIC_REG_PRI0) ? 8'h01 : 8'h00))
                      | ev[r]) & MASK[r];
    assign wake_vec[r] = ev[r] & ~regs_q[r];
  end

  // ========================================================================
  // Register bank; everything clears to zero
  always_ff @(posedge clock)
  begin
    for (int r = 0; r < `MIC_REG_COUNT; r++)
    begin
      regs_q[r] <= rst ? `MIC_RESET_VAL : regs_d[r];
    end
  end

  // ========================================================================
  // Read port: data in the cycle after the strobe, zero otherwise
  logic [7:0] rd_sel;
  assign rd_sel = reg_rd ? (regs_q[reg_addr] & MASK[reg_addr]) : 8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rd_sel;
    end
  end

  // ========================================================================
  // Core request, return address and wake pulse
  logic wake_any;
  always_comb
  begin
    wake_any = 1'b0;
    for (int r = 0; r < `MIC_REG_COUNT; r++)
    begin
      wake_any = wake_any | (|wake_vec[r]);
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      irq_q  <= '0;
      ret_q  <= '0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q  <= irq_d;
      ret_q  <= accept ? next_pc : ret_q;
      wake_q <= wake_any;
    end
  end

  // The core pops ret_q on its return instruction; nothing to track here
  assign irq          = irq_q;
  assign irq_ret_addr = ret_q;
  assign wake         = wake_q;
  assign reg_rdata    = rdata_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [`MIC_NUM_SRC-1:0] pend_q;
  always_ff @(posedge clock)
  begin
    pend_q <= rst ? '0 : pend;
  end

  a_global_block: assert property (!gie |=> !irq.take)
    else $error("interrupt accepted with global enable clear");
  a_stack_defer: assert property (stack_full |=> !irq.take)
    else $error("interrupt accepted with stack full");
  a_take_clears_gie: assert property (irq.take |-> !regs_q[`MIC_REG_PRI0][0])
    else $error("global enable still set after accept");
  a_enable_gate: assert property (irq.take |-> pend_q[irq.index])
    else $error("accepted source was not enabled and flagged");
  a_fixed_priority: assert property
    (irq.take |-> (pend_q & ((13'h0001 << irq.index) - 13'h0001)) == '0)
    else $error("higher priority request was passed over");
  a_cmp_flag_set: assert property (src_event.comparator |=> regs_q[`MIC_REG_PRI0][5])
    else $error("comparator event did not set its flag");
  a_group_set: assert property
    (src_event.low_supply && regs_q[`MIC_REG_SHR2][0] |=> regs_q[`MIC_REG_PRI1][5])
    else $error("group flag not set by enabled member");
  a_direct_clear: assert property
    (accept && win == 4'h1 && !src_event.comparator && !reg_wr
     |=> !regs_q[`MIC_REG_PRI0][5] && irq.vector == 8'h08)
    else $error("direct flag not cleared on service");
  a_member_kept: assert property
    (accept && win == 4'h4 && !reg_wr |=> regs_q[`MIC_REG_SHR2][5:4] == $past(regs_q[7][5:4]))
    else $error("group member flags changed on service");
  a_wake_new: assert property
    (src_event.comparator && !regs_q[`MIC_REG_PRI0][5] |=> wake)
    else $error("new flag did not wake");
  a_reserved_zero: assert property ((reg_rdata & 8'hc0) == 8'h00 || $past(reg_addr) != 3'h0)
    else $error("reserved edge bits read nonzero");

  c_take: cover property (irq.take);
  c_nested: cover property (irq.take ##[1:20] irq.take);
  c_deferred: cover property (stack_full && gie && any_pend ##1 !stack_full ##1 irq.take);
  c_group: cover property (irq.take && irq.index == 4'h2);

endmodule

`default_nettype wire

// ---- verif/mic_core_model.sv ----
// Behavioural core model: return stack, program counter and return pop.
// Assumes irq.take is a one-cycle pulse and return_from_interrupt a one-cycle bench pulse.
`default_nettype none

module mic_core_model #(
  parameter int PC_W  = 14,
  parameter int DEPTH = 2
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire mic_pkg::mic_irq_t irq,
  input  wire logic [PC_W-1:0]   ret_addr,
  input  wire logic              return_from_interrupt,
  output logic                   stack_full,
  output logic [PC_W-1:0]        next_pc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [PC_W-1:0] stack_q [DEPTH];
  logic [3:0]      depth_q;

  // Full as soon as the last level is used; a shallow stack tests deferral
  assign stack_full = (depth_q == 4'(DEPTH));

  // Push and jump on accept, pop on return, else step to the next word
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      depth_q <= 4'h0;
      next_pc <= '0;
    end
    else if (irq.take)
    begin
      stack_q[depth_q] <= ret_addr;
      depth_q          <= depth_q + 4'h1;
      next_pc          <= PC_W'(irq.vector);
    end
    else if (return_from_interrupt && depth_q != 4'h0)
    begin
      depth_q <= depth_q - 4'h1;
      next_pc <= stack_q[depth_q - 4'h1];
    end
    else
    begin
      next_pc <= next_pc + PC_W'(1);
    end
  end
endmodule

`default_nettype wire

// ---- verif/mcu_interrupt_controller_tb.sv ----
// Self-checking bench of the interrupt controller beside a core model.
// Assumes mic_pkg and the design files are compiled before this file.
`include "mic_defines.svh"
`default_nettype none

module mcu_interrupt_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [2:0]  mreg;
    logic [7:0]  mval;
    logic [7:0]  mexp;
    logic [2:0]  preg;
    logic [7:0]  pval;
    logic [7:0]  pexp;
    logic [16:0] src;
    logic [1:0]  pin;
    logic [3:0]  idx;
  } mic_row_t;

  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [2:0]        reg_addr = 3'h0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_rdata;
  logic [2:0]        ext_pin = 3'h0;
  mic_pkg::mic_src_t src_event = '0;
  logic              stack_full;
  logic [13:0]       next_pc;
  mic_pkg::mic_irq_t irq;
  logic [13:0]       irq_ret_addr;
  logic [13:0]       ret_exp;
  logic              wake;
  logic              return_from_interrupt = 1'b0;
  logic [3:0]        last_idx;
  logic [7:0]        last_vec;
  mic_row_t          r;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                take_cnt = 0;
  int                wake_cnt = 0;
  int                n_take = 0;
  int                n_wake = 0;
  logic [7:0]        masks [8] = '{`MIC_MASK_EDGE, `MIC_MASK_PRI0, `MIC_MASK_FULL,
    `MIC_MASK_FULL, `MIC_MASK_HALF, `MIC_MASK_FULL, `MIC_MASK_FULL, `MIC_MASK_HALF};

  // ========================================================================
  // One row per direct source and two per group: setup, event, expected index and read-back
  mic_row_t rows [16] = '{
    '{3'h0,8'h01,8'h01,3'h1,8'h03,8'h02,17'h00000,2'h0,4'h0},
    '{3'h0,8'h00,8'h00,3'h1,8'h05,8'h04,17'h10000,2'h3,4'h1},
    '{3'h5,8'h08,8'h88,3'h1,8'h09,8'h08,17'h00020,2'h3,4'h2},
    '{3'h5,8'h01,8'h11,3'h1,8'h09,8'h08,17'h00040,2'h3,4'h2},
    '{3'h6,8'h08,8'h88,3'h2,8'h01,8'h01,17'h00200,2'h3,4'h3},
    '{3'h6,8'h01,8'h11,3'h2,8'h01,8'h01,17'h00004,2'h3,4'h3},
    '{3'h7,8'h02,8'h22,3'h2,8'h02,8'h02,17'h00002,2'h3,4'h4},
    '{3'h7,8'h01,8'h11,3'h2,8'h02,8'h02,17'h00001,2'h3,4'h4},
    '{3'h0,8'h00,8'h00,3'h2,8'h04,8'h04,17'h08000,2'h3,4'h5},
    '{3'h0,8'h00,8'h00,3'h2,8'h08,8'h08,17'h04000,2'h3,4'h6},
    '{3'h0,8'h00,8'h00,3'h3,8'h01,8'h01,17'h02000,2'h3,4'h7},
    '{3'h0,8'h04,8'h04,3'h3,8'h02,8'h02,17'h00000,2'h1,4'h8},
    '{3'h0,8'h00,8'h00,3'h3,8'h04,8'h04,17'h01000,2'h3,4'h9},
    '{3'h0,8'h00,8'h00,3'h3,8'h08,8'h08,17'h00800,2'h3,4'ha},
    '{3'h0,8'h00,8'h00,3'h4,8'h01,8'h01,17'h00400,2'h3,4'hb},
    '{3'h0,8'h10,8'h10,3'h4,8'h02,8'h02,17'h00000,2'h2,4'hc}};

  mic_intc #(.PC_W(14)) mic_intc_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin(ext_pin), .src_event(src_event), .stack_full(stack_full), .next_pc(next_pc),
    .irq(irq), .irq_ret_addr(irq_ret_addr), .wake(wake));

  mic_core_model #(.PC_W(14), .DEPTH(2)) mic_core_model_inst (.clock(clock), .rst(rst),
    .irq(irq), .ret_addr(irq_ret_addr), .return_from_interrupt(return_from_interrupt), .stack_full(stack_full),
    .next_pc(next_pc));

  // ========================================================================
  // Clock and watchdog; the run needs well under 5000 cycles
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  initial
  begin
    #(5000 * 25);
    error_cnt++;
    print_verdict();
  end

  // Takes and wake pulses, seen where settled
  always @(negedge clock)
  begin
    if (wake === 1'b1)
      wake_cnt++;
    if (irq.take === 1'b1)
    begin
      take_cnt++;
      last_idx = irq.index;
      last_vec = irq.vector;
      ret_exp  = next_pc - 14'h0001;
      chk("return address", 16'(ret_exp), 16'(irq_ret_addr));
    end
  end

  // ========================================================================
  // Compare, bus cycles, events and verdict
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(name, 16'(exp), 16'(reg_rdata));
  endtask

  task automatic pulse(input logic [16:0] m, input logic [1:0] pin);
    n_wake = wake_cnt;
    @(posedge clock);
    src_event <= mic_pkg::mic_src_t'(m);
    if (pin != 2'h3)
      ext_pin[pin] <= 1'b1;
    @(posedge clock);
    src_event <= '0;
    ext_pin   <= 3'h0;
  endtask

  // Service routine end; the core model pops the saved address
  task automatic ret1();
    @(posedge clock);
    return_from_interrupt <= 1'b1;
    @(posedge clock);
    return_from_interrupt <= 1'b0;
  endtask

  // Bounded wait, then number of takes and, if any, the last index and vector
  task automatic expect_take(input int n, input logic [3:0] idx);
    repeat (8) @(posedge clock);
    chk("take count", 16'(n), 16'(take_cnt - n_take));
    if (n > 0)
    begin
      chk("index", 16'(idx), 16'(last_idx));
      chk("vector", 16'(`MIC_VEC_BASE + `MIC_VEC_STEP * idx), 16'(last_vec));
    end
    n_take = take_cnt;
  endtask

  task automatic print_verdict();
    $display("Checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd_chk("reset value", 3'(a), `MIC_RESET_VAL);
    for (int a = 0; a < 8; a++) wr(3'(a), 8'hfe);
    for (int a = 0; a < 8; a++) rd_chk("read back", 3'(a), 8'hfe & masks[a]);
    // Reset in mid-run with flags and enables set
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd_chk("second reset", `MIC_REG_PRI1, 8'h00);
    // Every edge mode against a rising and then a falling pin edge
    for (int m = 0; m < 4; m++)
    begin
      wr(`MIC_REG_EDGE, 8'(m));
      @(posedge clock);
      ext_pin <= 3'h1;
      repeat (3) @(posedge clock);
      rd_chk("rising", `MIC_REG_PRI0, {3'h0, 1'(m), 4'h0});
      wr(`MIC_REG_PRI0, 8'h00);
      ext_pin <= 3'h0;
      repeat (3) @(posedge clock);
      rd_chk("falling", `MIC_REG_PRI0, {3'h0, 1'(m >> 1), 4'h0});
      wr(`MIC_REG_PRI0, 8'h00);
    end
    wr(`MIC_REG_EDGE, 8'h00);
    // Each direct source and two members of each group alone through its own or its group vector
    for (int i = 0; i < 16; i++)
    begin
      r = rows[i];
      wr(r.mreg, r.mval);
      wr(r.preg, r.pval);
      if (r.preg != `MIC_REG_PRI0)
        wr(`MIC_REG_PRI0, 8'h01);
      pulse(r.src, r.pin);
      expect_take(1, r.idx);
      chk("wake", 16'h1, 16'(wake_cnt != n_wake));
      rd_chk("member reg", r.mreg, r.mexp);
      rd_chk("primary reg", r.preg, r.pexp);
      rd_chk("control 0", `MIC_REG_PRI0, (r.preg == `MIC_REG_PRI0) ? r.pexp : 8'h00);
      ret1();
      wr(r.mreg, 8'h00);
      wr(r.preg, 8'h00);
    end
    // Blocked request stays pending, priority, nesting, then a full stack
    wr(`MIC_REG_PRI1, 8'h4c);
    wr(`MIC_REG_PRI0, 8'h04);
    pulse(17'h10000, 2'h3);
    expect_take(0, 4'h0);
    rd_chk("pending", `MIC_REG_PRI0, 8'h24);
    wr(`MIC_REG_PRI0, 8'h25);
    expect_take(1, 4'h1);
    wr(`MIC_REG_PRI0, 8'h05);
    expect_take(1, 4'h5);
    wr(`MIC_REG_PRI0, 8'h05);
    pulse(17'h04000, 2'h3);
    expect_take(0, 4'h0);
    rd_chk("held while full", `MIC_REG_PRI1, 8'h8c);
    ret1();
    expect_take(1, 4'h6);
    ret1();
    ret1();
    // Member without enable leaves the group flag clear; a preset flag stays quiet
    pulse(17'h00040, 2'h3);
    rd_chk("member only", `MIC_REG_SHR0, 8'h10);
    rd_chk("no group flag", `MIC_REG_PRI0, 8'h04);
    chk("wake", 16'h1, 16'(wake_cnt != n_wake));
    pulse(17'h00040, 2'h3);
    repeat (4) @(posedge clock);
    chk("no wake", 16'h0, 16'(wake_cnt != n_wake));
    print_verdict();
  end
endmodule

`default_nettype wire
